// ### hdl/rotate_sub_swap_return_exec.v
// Purpose: Executes return, rotates, subtract with borrow and nibble swap.
// Assumes: One instruction per cycle on instrValid; the file read data arrive combinationally.
// Notes: The call stack itself lives outside; this block asks for a pop and takes its head.
`timescale 1ns/10ps
`include "exec_consts.vh"
module rotate_sub_swap_return_exec
(
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Instruction
  input wire instrValid,
  input wire [15:0] instrWord,
  input wire extendedEn,
  // Call stack
  input wire [20:0] stack_head,
  output wire stackPop,
  // File access
  input wire [11:0] indexBase,
  output wire [11:0] fileRdAddr,
  input wire [7:0] fileRdData,
  output reg fileWrEn,
  output reg [11:0] fileWrAddr,
  output reg [7:0] fileWrData,
  // Shadow registers
  input wire [7:0] acc_shadow,
  input wire [7:0] flags_shadow,
  input wire [3:0] bank_pointer_shadow,
  // Core state
  output reg [7:0] acc,
  output reg [7:0] flags,
  output reg [3:0] bank_pointer,
  output reg [20:0] pc,
  output reg pcLoad,
  output wire busy,
  output reg illegalOp
);
  ////////////////////////////////////////////////////////////////////////////
  localparam ST_EXEC = 1'b0;
  localparam ST_IDLE2 = 1'b1;
  reg state;
  reg next_state;
  wire isReturn;
  reg isRlnc;
  reg isSubb;
  reg isSwap;
  reg isRlc;
  reg isRrc;
  wire dBit;
  wire aBit;
  wire byteOp;
  wire take;
  wire restore;
  reg [7:0] result;
  reg [7:0] next_flags;
  reg [8:0] diff;

  function [7:0] setNZ;
    input [7:0] f;
    input [7:0] r;
    begin
      setNZ = f;
      setNZ[`FLAG_N] = r[7];
      setNZ[`FLAG_Z] = (r == 8'h00);
    end
  endfunction

  // Shifts one place left; the caller picks what enters bit 0.
  function [7:0] rotLeft;
    input [7:0] v;
    input fill;
    begin
      rotLeft = {v[6:0], fill};
    end
  endfunction

  // Shifts one place right; the caller picks what enters bit 7.
  function [7:0] rotRight;
    input [7:0] v;
    input fill;
    begin
      rotRight = {fill, v[7:1]};
    end
  endfunction

  function [7:0] swapNibbles;
    input [7:0] v;
    begin
      swapNibbles = {v[3:0], v[7:4]};
    end
  endfunction

  // Nine-bit difference: bit 8 is set when the subtraction borrows.
  function [8:0] subBorrow;
    input [7:0] minuend;
    input [7:0] subtrahend;
    input carryIn;
    begin
      subBorrow = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, ~carryIn};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Opcode decode.
  assign isReturn = (instrWord[`OPC_MSB:`RET_LSB] == `OPC_RETURN_HI);
  assign dBit = instrWord[`DEST_BIT];
  assign aBit = instrWord[`ACCESS_BIT];
  assign byteOp = isRlc || isRrc || isRlnc || isSubb || isSwap;

  // The rotate group shares its upper nibble; the two bits below it pick the operation.
  always @*
  begin
    isRlc = 1'b0;
    isRrc = 1'b0;
    isSwap = 1'b0;
    isRlnc = 1'b0;
    isSubb = 1'b0;
    if (instrWord[`OPC_MSB:`GRP_LSB] == `OPC_ROT_HI)
    begin
      case (instrWord[`SUB_MSB:`SUB_LSB])
        `SUB_RLC:
        begin
          isRlc = 1'b1;
        end
        `SUB_RRC:
        begin
          isRrc = 1'b1;
        end
        `SUB_SWAP:
        begin
          isSwap = 1'b1;
        end
        default:
        begin
          isSwap = 1'b0;
        end
      endcase
    end
    else if (instrWord[`OPC_MSB:`OP6_LSB] == `OPC_RLNC_HI)
    begin
      isRlnc = 1'b1;
    end
    else if (instrWord[`OPC_MSB:`OP6_LSB] == `OPC_SUBB_HI)
    begin
      isSubb = 1'b1;
    end
  end

  file_addr_resolve u_resolve
  (
    .fileAddr(instrWord[7:0]),
    .bankAccess(aBit),
    .extendedEn(extendedEn),
    .bank_pointer(bank_pointer),
    .indexBase(indexBase),
    .dataAddr(fileRdAddr),
    .indexedMode()
  );

  // Instructions are taken only in the execute state; the idle return cycle refuses them.
  assign take = instrValid && (state == ST_EXEC);
  assign restore = take && isReturn && instrWord[`RET_OPT_BIT];

  // The pop request is a one-cycle handshake in the execute cycle.
  assign stackPop = take && isReturn;
  assign busy = (state == ST_IDLE2);

  ////////////////////////////////////////////////////////////////////////////
  // Byte operation datapath.
  always @*
  begin
    result = fileRdData;
    next_flags = flags;
    diff = subBorrow(fileRdData, acc, flags[`FLAG_C]);
    if (isRlc)
    begin
      result = rotLeft(fileRdData, flags[`FLAG_C]);
      next_flags = setNZ(flags, result);
      next_flags[`FLAG_C] = fileRdData[7];
    end
    else if (isRrc)
    begin
      result = rotRight(fileRdData, flags[`FLAG_C]);
      next_flags = setNZ(flags, result);
      next_flags[`FLAG_C] = fileRdData[0];
    end
    else if (isRlnc)
    begin
      // Carry is kept: only N and Z follow the result.
      result = rotLeft(fileRdData, fileRdData[7]);
      next_flags = setNZ(flags, result);
    end
    else if (isSubb)
    begin
      result = diff[7:0];
      next_flags = setNZ(flags, result);
      next_flags[`FLAG_C] = ~diff[8];
    end
    else if (isSwap)
    begin
      // The flags are left exactly as they were.
      result = swapNibbles(fileRdData);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Return sequencing: execute cycle, then one idle cycle.
  always @*
  begin
    next_state = ST_EXEC;
    case (state)
      ST_EXEC:
      begin
        if (instrValid && isReturn)
        begin
          next_state = ST_IDLE2;
        end
      end
      ST_IDLE2:
      begin
        next_state = ST_EXEC;
      end
      default:
      begin
        next_state = ST_EXEC;
      end
    endcase
  end

  // State register.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_EXEC;
    end
    else
    begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator: loaded by a restoring return or by a byte operation aimed at it.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc <= 8'h00;
    end
    else if (restore)
    begin
      acc <= acc_shadow;
    end
    else if (take && byteOp && !dBit)
    begin
      acc <= result;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags: a plain return never writes them; the swap passes them through unchanged.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flags <= 8'h00;
    end
    else if (restore)
    begin
      flags <= flags_shadow;
    end
    else if (take && byteOp)
    begin
      flags <= next_flags;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bank pointer: only a restoring return writes it.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bank_pointer <= 4'h0;
    end
    else if (restore)
    begin
      bank_pointer <= bank_pointer_shadow;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program counter and its load strobe; the counter latches live elsewhere and stay put.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pc <= 21'h00_0000;
      pcLoad <= 1'b0;
    end
    else
    begin
      pcLoad <= 1'b0;
      if (take && isReturn)
      begin
        pc <= stack_head;
        pcLoad <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // File write port: one strobe for each byte operation that writes back.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fileWrEn <= 1'b0;
      fileWrAddr <= 12'h000;
      fileWrData <= 8'h00;
    end
    else
    begin
      fileWrEn <= 1'b0;
      if (take && byteOp && dBit)
      begin
        fileWrEn <= 1'b1;
        fileWrAddr <= fileRdAddr;
        fileWrData <= result;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Marks an opcode this block does not execute; no state changes for it.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      illegalOp <= 1'b0;
    end
    else
    begin
      illegalOp <= take && !isReturn && !byteOp;
    end
  end
endmodule

// ### hdl/exec_consts.vh
// Purpose: Constants for the rotate, subtract, swap and return execution block.
// Assumes: One core clock, asynchronous active-low reset.
// Notes: Opcode fields follow the 16-bit instruction word layout.
//
// How it works
// - Return pops the call stack and loads the stack head into the PC.
// - Return with option bit 1 restores accumulator, flags and bank pointer.
// - Return with option bit 0 leaves accumulator, flags and bank pointer alone.
// - Return leaves the PC latches unchanged; the status flags change only when option bit 1 restores them.
// - Rotate left through carry: bit 7 to carry, old carry into bit 0; C N Z.
// - Rotate right through carry: bit 0 to carry, old carry into bit 7; C N Z.
// - Subtract with borrow: f minus W minus not carry; C is not-borrow; Z N.
// - Nibble swap exchanges the two nibbles and leaves the flags alone.
// - Destination bit 0 writes the result to the accumulator only.
// - Destination bit 1 writes the result back to the file location.
// - Bank-access bit 0 resolves the address in the access bank.
// - Bank-access bit 1 joins the bank pointer and the address.
// - Extended set, access bit 0, address up to 95: indexed literal offset.
`ifndef EXEC_CONSTS_VH
`define EXEC_CONSTS_VH
`define OPC_RETURN_HI 15'h0009
`define OPC_ROT_HI 4'h3
`define OPC_RLNC_HI 6'h11
`define OPC_SUBB_HI 6'h16
`define SUB_RRC 2'h0
`define SUB_RLC 2'h1
`define SUB_SWAP 2'h2
`define ACCESS_SPLIT 8'h60
`define ACCESS_LITERAL_MAX 8'h5F
`define ACCESS_HIGH_BANK 4'hF
`define FLAG_C 0
`define FLAG_Z 2
`define FLAG_N 4
`define OPC_MSB 15
`define RET_LSB 1
`define GRP_LSB 12
`define SUB_MSB 11
`define SUB_LSB 10
`define OP6_LSB 10
`define DEST_BIT 9
`define ACCESS_BIT 8
`define RET_OPT_BIT 0
`endif

// ### hdl/file_addr_resolve.v
// Purpose: Resolves a byte-instruction file operand into a 12-bit data address.
// Assumes: Combinational; the caller registers anything it needs to hold.
// Notes: Indexed literal offset adds the address to the index register.
`timescale 1ns/10ps
`include "exec_consts.vh"
module file_addr_resolve
(
  // Operand fields
  input wire [7:0] fileAddr,
  input wire bankAccess,
  input wire extendedEn,
  // Bank and index state
  input wire [3:0] bank_pointer,
  input wire [11:0] indexBase,
  // Result
  output reg [11:0] dataAddr,
  output reg indexedMode
);
  // One bit wider than the data space; the top bit is dropped so the offset wraps.
  reg [12:0] offsetSum;

  always @*
  begin
    offsetSum = {1'b0, indexBase} + {5'h00, fileAddr};
    indexedMode = 1'b0;
    if (bankAccess)
    begin
      dataAddr = {bank_pointer, fileAddr};
    end
    else if (extendedEn && (fileAddr <= `ACCESS_LITERAL_MAX))
    begin
      indexedMode = 1'b1;
      dataAddr = offsetSum[11:0];
    end
    else if (fileAddr < `ACCESS_SPLIT)
    begin
      dataAddr = {4'h0, fileAddr};
    end
    else
    begin
      dataAddr = {`ACCESS_HIGH_BANK, fileAddr};
    end
  end
endmodule

// ### verification/exec_asserts.sv
// Purpose: Temporal checks on the execution block ports.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Bound to every instance of the block.
`timescale 1ns/10ps
module exec_asserts
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Instruction and stack
  input wire logic instrValid,
  input wire logic [15:0] instrWord,
  input wire logic busy,
  input wire logic stackPop,
  input wire logic [20:0] stack_head,
  // File access
  input wire logic [11:0] fileRdAddr,
  input wire logic [7:0] fileRdData,
  input wire logic fileWrEn,
  input wire logic [11:0] fileWrAddr,
  input wire logic [7:0] fileWrData,
  // Shadows and state
  input wire logic [7:0] acc_shadow,
  input wire logic [7:0] flags_shadow,
  input wire logic [3:0] bank_pointer_shadow,
  input wire logic [7:0] acc,
  input wire logic [7:0] flags,
  input wire logic [3:0] bank_pointer,
  input wire logic [20:0] pc,
  input wire logic pcLoad
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  wire take = instrValid && !busy;
  wire isRet = take && instrWord[15:1] == 15'h0009;
  wire [5:0] op = instrWord[15:10];
  wire isByte = take && (op == 6'h0C || op == 6'h0D || op == 6'h0E || op == 6'h11 || op == 6'h16);
  sequence s_load;
    stackPop ##1 pcLoad && pc == $past(stack_head);
  endsequence
  sequence s_settle;
    busy ##1 !busy;
  endsequence
  property p_pop; isRet |-> s_load; endproperty
  a_pop: assert property (p_pop) else $error("return did not load pc");
  property p_restore; isRet && instrWord[0] |=> acc == $past(acc_shadow) && flags == $past(flags_shadow)
    && bank_pointer == $past(bank_pointer_shadow); endproperty
  a_restore: assert property (p_restore) else $error("shadow restore wrong");
  property p_keep; isRet && !instrWord[0] |=> $stable(acc) && $stable(flags) && $stable(bank_pointer); endproperty
  a_keep: assert property (p_keep) else $error("plain return changed state");
  property p_busy; isRet |=> s_settle; endproperty
  a_busy: assert property (p_busy) else $error("return length wrong");
  property p_swap; isByte && op == 6'h0E |=> $stable(flags)
    && (fileWrEn ? fileWrData : acc) == {$past(fileRdData[3:0]), $past(fileRdData[7:4])}; endproperty
  a_swap: assert property (p_swap) else $error("swap wrong");
  property p_dest; isByte |=> fileWrEn == $past(instrWord[9]); endproperty
  a_dest: assert property (p_dest) else $error("destination wrong");
  property p_waddr; isByte && instrWord[9] |=> fileWrAddr == $past(fileRdAddr); endproperty
  a_waddr: assert property (p_waddr) else $error("write address wrong");
  property p_bank; isByte && instrWord[8] |-> fileRdAddr == {bank_pointer, instrWord[7:0]}; endproperty
  a_bank: assert property (p_bank) else $error("banked address wrong");
  property p_rlc; isByte && op == 6'h0D |=> flags[0] == $past(fileRdData[7]); endproperty
  a_rlc: assert property (p_rlc) else $error("left carry wrong");
  property p_rrc; isByte && op == 6'h0C |=> flags[0] == $past(fileRdData[0]); endproperty
  a_rrc: assert property (p_rrc) else $error("right carry wrong");
endmodule
bind rotate_sub_swap_return_exec exec_asserts exec_asserts_inst (.*);

// ### verification/tb.sv
// Purpose: Self-checking bench for the execution block.
// Assumes: Inputs change by non-blocking assignment at the rising edge.
// Notes: Each op checks the results of the one before it.
`timescale 1ns/10ps
module tb;
  logic clk = 0, rst_n = 0, instrValid = 0, extendedEn = 0;
  logic [15:0] instrWord = 16'h0000;
  logic [20:0] stack_head = 21'h00_0000, pc, mPc;
  logic [11:0] indexBase = 12'h000, fileRdAddr, fileWrAddr, eAddr;
  logic [7:0] fileRdData = 8'h00, acc_shadow = 8'h00, flags_shadow = 8'h00, fileWrData, acc, flags, mAcc, mFlags, eData;
  logic [3:0] bank_pointer_shadow = 4'h0, bank_pointer, mBank;
  logic stackPop, fileWrEn, pcLoad, busy, illegalOp, eWr, ePc, mBusy, eIll;
  int num_errors = 0, n_checks = 0, cyc = 0;
  rotate_sub_swap_return_exec rotate_sub_swap_return_exec_inst (.*);
  initial forever #25 clk = ~clk;
  always @(posedge clk)
    if (++cyc == 2000)
    begin
      num_errors++;
      conclude();
    end
  task conclude;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input string nm, input logic [20:0] s, e);
    n_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  function logic [15:0] mk(input int k, input logic [9:0] da);
    case (k)
      0, 1, 2: mk = {4'h3, k[1:0], da};
      3: mk = {6'h11, da};
      4: mk = {6'h16, da};
      default: mk = {15'h0009, da[0]};
    endcase
  endfunction
  task op(input logic [15:0] w, input logic [7:0] f);
    logic [7:0] r;
    logic c, b;
    begin
      @(posedge clk);
      instrValid <= 1'b1;
      instrWord <= w;
      fileRdData <= f;
      {stack_head, acc_shadow, flags_shadow, bank_pointer_shadow, indexBase, extendedEn} <= 54'({$urandom, $urandom});
      #1;
      chk("acc", acc, mAcc);
      chk("flags", flags, mFlags);
      chk("bank", bank_pointer, mBank);
      chk("pc", pc, mPc);
      chk("pcLoad", pcLoad, ePc);
      chk("busy", busy, mBusy);
      chk("wrEn", fileWrEn, eWr);
      if (eWr) chk("write", {fileWrAddr, fileWrData}, {eAddr, eData});
      chk("illegal", illegalOp, eIll);
      chk("pop", stackPop, !mBusy && w[15:1] == 15'h0009);
      {eWr, ePc, eIll} = 3'b000;
      if (mBusy) mBusy = 0;
      else if (w[15:1] == 15'h0009)
      begin
        {mPc, ePc, mBusy} = {stack_head, 2'b11};
        if (w[0]) {mAcc, mFlags, mBank} = {acc_shadow, flags_shadow, bank_pointer_shadow};
      end
      else
      begin
        eAddr = w[8] ? {mBank, w[7:0]} : (extendedEn && w[7:0] <= 8'h5F) ? indexBase + w[7:0] : {{4{w[7:0] >= 8'h60}}, w[7:0]};
        chk("rdAddr", fileRdAddr, eAddr);
        eIll = !(w[15:10] inside {6'h0C, 6'h0D, 6'h0E, 6'h11, 6'h16});
        c = mFlags[0];
        b = 0;
        case (w[15:10])
          6'h0C: {r, c} = {c, f};
          6'h0D: {c, r} = {f, c};
          6'h0E: r = {f[3:0], f[7:4]};
          6'h11: r = {f[6:0], f[7]};
          default: {b, r} = {1'b0, f} - mAcc - !c;
        endcase
        if (w[15:10] == 6'h16) c = !b;
        if (!eIll)
        begin
          if (w[15:10] != 6'h0E) {mFlags[4], mFlags[2], mFlags[0]} = {r[7], r == 8'h00, c};
          if (w[9]) {eWr, eData} = {1'b1, r};
          else mAcc = r;
        end
      end
    end
  endtask
  initial
  begin
    {mAcc, mFlags, mBank, mPc, eWr, ePc, mBusy, eIll} = 0;
    void'($urandom(44011));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    op(16'h0013, 8'h00);
    op(mk(0, 10'h0FF), 8'hAA);
    op(16'h3C55, 8'h12);
    op(16'hF3A0, 8'h34);
    for (int k = 0; k < 5; k++)
      for (int j = 0; j < 4; j++)
        op(mk(k, {j[1], 1'b0, 8'h5F + j[0]}), 8'h80 >> j);
    $display("corner test done");
    repeat (400) op(mk($urandom_range(5), 10'($urandom)), 8'($urandom));
    $display("random test done");
    repeat (2) op(16'h0012, 8'h00);
    op(mk(2, 10'h100), 8'h5A);
    $display("return test done");
    conclude();
  end
endmodule
